// ---- common/vps_pkg.sv ----
// Purpose: Shared constants and types for the voice PCM serial port
// Assumes: 20 MHz APB clock, 32-bit APB data, byte addresses
// Notes:   Configuration word fields are laid out by the packed struct below
package vps_pkg;

    localparam int unsigned CLK_HZ    = 20_000_000;
    localparam int unsigned SAMPLE_HZ = 8_000;
    localparam int unsigned LINKS     = 3;
    localparam int unsigned POS_W     = 11;

    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_CLOCK  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_MASK  = 32'h07FF_FFFF;
    // Half period 20 cycles (500 kHz), frame of 8 x 8 bits
    localparam logic [31:0] CLOCK_RESET  = 32'h0000_0814;

    localparam int unsigned CLK_HALF_LSB   = 0;
    localparam int unsigned CLK_SLIMIT_LSB = 8;
    localparam int unsigned STAT_FCNT_LSB  = 16;

    // Low-power clock source rates
    localparam int unsigned LP_HZ_0 = 128_000;
    localparam int unsigned LP_HZ_1 = 256_000;
    localparam int unsigned LP_HZ_2 = 512_000;
    localparam logic [7:0] LP_HALF_0 = 8'(CLK_HZ / (2 * LP_HZ_0));
    localparam logic [7:0] LP_HALF_1 = 8'(CLK_HZ / (2 * LP_HZ_1));
    localparam logic [7:0] LP_HALF_2 = 8'(CLK_HZ / (2 * LP_HZ_2));
    localparam logic [POS_W-1:0] LP_FRAME_0 = POS_W'(LP_HZ_0 / SAMPLE_HZ);
    localparam logic [POS_W-1:0] LP_FRAME_1 = POS_W'(LP_HZ_1 / SAMPLE_HZ);
    localparam logic [POS_W-1:0] LP_FRAME_2 = POS_W'(LP_HZ_2 / SAMPLE_HZ);

    localparam logic [POS_W-1:0] SYNC_LONG_BITS   = 11'h008;
    localparam logic [POS_W-1:0] SYNC_LONG16_BITS = 11'h010;

    typedef enum logic [1:0] {
        SYNC_LONG  = 2'h0,
        SYNC_SHORT = 2'h1,
        SYNC_GCI   = 2'h2,
        SYNC_RSVD  = 2'h3
    } vps_sync_type;

    typedef enum logic [1:0] {
        FMT_LIN13 = 2'h0,
        FMT_LIN16 = 2'h1,
        FMT_ULAW  = 2'h2,
        FMT_ALAW  = 2'h3
    } vps_fmt_type;

    typedef enum logic [1:0] {
        FILL_SIGN  = 2'h0,
        FILL_ZERO  = 2'h1,
        FILL_ATTEN = 2'h2,
        FILL_RSVD  = 2'h3
    } vps_fill_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_HUNT = 3'h2,
        ST_RUN  = 3'h4
    } vps_state_type;

    typedef struct packed {
        logic       en;
        logic [1:0] slot;
    } vps_link_map_type;

    // audio_port_config_word
    typedef struct packed {
        logic [4:0]                   rsvd;
        vps_link_map_type [LINKS-1:0] link;
        logic                         run;
        logic [1:0]                   lp_rate;
        logic                         long16;
        logic                         hi_rate;
        logic                         late_release;
        logic [2:0]                   atten;
        vps_fill_type                 fill;
        logic                         lsb_first;
        vps_fmt_type                  fmt;
        logic                         slot16;
        vps_sync_type                 sync_fmt;
        logic                         master;
    } vps_cfg_type;

    typedef struct packed {
        logic clk;
        logic sync;
        logic data;
    } vps_pin_in_type;

    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic sync_o;
        logic sync_oe;
        logic data_o;
        logic data_oe;
    } vps_pin_out_type;

    typedef struct packed {
        logic [LINKS-1:0][15:0] sample;
    } vps_link_tx_type;

    typedef struct packed {
        logic [LINKS-1:0]       valid;
        logic [LINKS-1:0][15:0] sample;
    } vps_link_rx_type;

endpackage

// ---- logic/vps_voice_pcm_serial_port.sv ----
// Purpose: Synchronous PCM voice serial port, master or slave, up to three links
// Assumes: Bit clock well below pclk/4; pins are synchronised before use
// Notes:   Options take effect only when run is set again from idle
// Functional notes
// R1: As master, drive bit clock and frame sync ourselves.
// R2: As slave, far end supplies bit clock and sync; we follow them.
// R3: Long sync: sync rising edge starts the sample word.
// R4: Long sync master holds sync high eight bit periods per frame.
// R5: Long sync slave accepts sync from one period to half a frame.
// R6: Short sync: falling edge starts the word; sync high one period.
// R7: Capture input on falling clock, launch output on rising clock; a long-sync or GCI slave launches its first bit on the fall that sees sync rise.
// R8: Output release at falling edge in last bit, or next rising edge.
// R9: Transfer in any subset of the first four slots after sync.
// R10: At most three links, each in its own slot of the first four.
// R11: Slots are 8 or 16 periods; 8-period slots carry 8-bit samples.
// R12: Formats: 13-bit linear, 16-bit linear, mu-law, A-law.
// R13: One sample per active slot per frame, 8 ksps.
// R14: Bit order selectable, little or big endian.
// R15: Spare bits in 16-period slots: sign, zeros or attenuation code.
// R16: GCI mode gives access to the two 64 kbps B channels.
// R17: GCI frame starts on sync rising edge, frames at 8 kHz.
// R18: Samples move by hardware straight to and from the voice links.
// R19: Low-power source offers 128, 256 or 512 kHz, sync 8 kHz.
// R20: High-rate source with long sync: sync 8 or 16 periods.
// R21: All options come from a config word loaded before starting; the high-rate half period and frame length come from the clock register.
// R22: First slot starts right after frame start; slots follow gapless.
`timescale 1ns/10ps
module vps_voice_pcm_serial_port (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire vps_pkg::vps_pin_in_type  pin_in,
    output vps_pkg::vps_pin_out_type      pin_out,
    input  wire vps_pkg::vps_link_tx_type link_tx,
    output vps_pkg::vps_link_rx_type      link_rx,
    output logic                          frame_strobe
);
    import vps_pkg::*;

    vps_cfg_type       cfg_q, cfg_d, act_q, act_d;
    logic [31:0]       clk_reg_q, clk_reg_d, clk_act_q, clk_act_d;
    logic [31:0]       prdata_q, prdata_d;
    logic              pready_q, pready_d, pslverr_q, pslverr_d;
    vps_state_type     state_q, state_d;
    logic [POS_W-1:0]  pos_q, pos_d;
    logic [7:0]        div_q, div_d;
    logic              pend_q, pend_d, syncp_q, syncp_d, strobe_q, strobe_d;
    logic [15:0]       fcnt_q, fcnt_d, rx_sh_q, rx_sh_d;
    vps_link_tx_type   tx_hold_q, tx_hold_d;
    vps_link_rx_type   rx_q, rx_d;
    vps_pin_out_type   pin_q, pin_d;
    logic [2:0]        sy1_q, sy2_q;
    logic              bclk_prev_q, bclk, rise, fall, launch, start;
    logic [POS_W-1:0]  frame_last;
    logic [3:0]        fall_bit;

    function automatic logic slot_is8(input vps_cfg_type c);
        return (c.sync_fmt == SYNC_GCI) || !c.slot16;
    endfunction

    function automatic logic [3:0] bit_in_slot(input vps_cfg_type c, input logic [POS_W-1:0] p);
        return slot_is8(c) ? {1'b0, p[2:0]} : p[3:0];
    endfunction

    function automatic logic [3:0] slot_last(input vps_cfg_type c);
        return slot_is8(c) ? 4'h7 : 4'hF;
    endfunction

    // Returns {hit, link index} of the link owning the slot at position p
    function automatic logic [2:0] link_of(input vps_cfg_type c, input logic [POS_W-1:0] p);
        logic [POS_W-1:0] sl;
        logic [2:0]       r;
        sl = slot_is8(c) ? (p >> 3) : (p >> 4);
        r  = 3'h0;
        for (int i = LINKS - 1; i >= 0; i--) begin
            if (c.link[i].en && sl == {{(POS_W-2){1'b0}}, c.link[i].slot}) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    // R14 bit order
    function automatic logic [3:0] bit_index(input vps_cfg_type c, input logic [3:0] b);
        return c.lsb_first ? b : (slot_last(c) - b);
    endfunction

    // R15 spare bits fill
    function automatic logic [15:0] build_word(input vps_cfg_type c, input logic [15:0] s);
        logic [2:0] f3;
        logic [7:0] f8;
        f3 = (c.fill == FILL_SIGN) ? {3{s[12]}} : (c.fill == FILL_ATTEN) ? c.atten : 3'h0;
        f8 = (c.fill == FILL_SIGN) ? {8{s[7]}} : (c.fill == FILL_ATTEN) ? {5'h00, c.atten} : 8'h00;
        if (slot_is8(c)) begin
            return {8'h00, s[7:0]};
        end
        // R12 sample formats
        case (c.fmt)
            FMT_LIN16: return s;
            FMT_LIN13: return {f3, s[12:0]};
            default:   return {f8, s[7:0]};
        endcase
    endfunction

    function automatic logic [15:0] extract(input vps_cfg_type c, input logic [15:0] w);
        if (slot_is8(c) || c.fmt == FMT_ULAW || c.fmt == FMT_ALAW) begin
            return {8'h00, w[7:0]};
        end
        return (c.fmt == FMT_LIN13) ? {{3{w[12]}}, w[12:0]} : w;
    endfunction

    // R11 slot sizes; R10 one slot per link
    function automatic logic cfg_err(input vps_cfg_type c);
        logic e;
        e = (c.sync_fmt == SYNC_RSVD) || (c.fill == FILL_RSVD);
        e = e || (slot_is8(c) && (c.fmt == FMT_LIN13 || c.fmt == FMT_LIN16));
        for (int i = 0; i < LINKS; i++) begin
            for (int j = i + 1; j < LINKS; j++) begin
                e = e || (c.link[i].en && c.link[j].en && c.link[i].slot == c.link[j].slot);
            end
        end
        return e;
    endfunction

    // R19 low-power rates; R20 high-rate frame
    function automatic logic [7:0] half_period(input vps_cfg_type c, input logic [31:0] k);
        logic [7:0] h;
        case (c.lp_rate)
            2'h0:    h = LP_HALF_0;
            2'h1:    h = LP_HALF_1;
            default: h = LP_HALF_2;
        endcase
        if (c.hi_rate) begin
            h = k[CLK_HALF_LSB +: 8];
        end
        return (h == 8'h00) ? 8'h01 : h;
    endfunction

    function automatic logic [POS_W-1:0] frame_len(input vps_cfg_type c, input logic [31:0] k);
        if (c.hi_rate) begin
            return {k[CLK_SLIMIT_LSB +: 8], 3'h0};
        end
        case (c.lp_rate)
            2'h0:    return LP_FRAME_0;
            2'h1:    return LP_FRAME_1;
            default: return LP_FRAME_2;
        endcase
    endfunction

    // APB slave: no wait states, answer registered in the setup cycle
    always_comb begin
        cfg_d     = cfg_q;
        clk_reg_d = clk_reg_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            pready_d = 1'b1;
            case (paddr)
                ADDR_CONFIG: prdata_d = cfg_q;
                ADDR_CLOCK:  prdata_d = clk_reg_q;
                ADDR_STATUS: prdata_d = {fcnt_q, 13'h0, cfg_err(cfg_q),
                                         state_q == ST_RUN, state_q != ST_IDLE};
                default: begin
                    prdata_d  = 32'h0000_0000;
                    pslverr_d = 1'b1;
                end
            endcase
        end
        if (psel && penable && pready_q && pwrite) begin
            case (paddr)
                ADDR_CONFIG: cfg_d = vps_cfg_type'(pwdata & CONFIG_MASK);
                ADDR_CLOCK:  clk_reg_d = pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q     <= vps_cfg_type'(CONFIG_RESET);
            clk_reg_q <= CLOCK_RESET;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            clk_reg_q <= clk_reg_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // R2 slave timing comes from the synchronised pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_q       <= 3'h0;
            sy2_q       <= 3'h0;
            bclk_prev_q <= 1'b0;
        end else begin
            sy1_q       <= pin_in;
            sy2_q       <= sy1_q;
            bclk_prev_q <= bclk;
        end
    end

    assign bclk       = act_q.master ? pin_q.clk_o : sy2_q[2];
    assign rise       = bclk && !bclk_prev_q && state_q != ST_IDLE;
    assign fall       = !bclk && bclk_prev_q && state_q != ST_IDLE;
    assign frame_last = frame_len(act_q, clk_act_q) - 11'h001;
    assign fall_bit   = bit_in_slot(act_q, start ? '0 : pos_q);

    always_comb begin
        logic [2:0]      hit;
        logic [3:0]      b;
        logic [15:0]     w;
        vps_link_tx_type src;
        hit       = 3'h0;
        b         = 4'h0;
        w         = 16'h0000;
        src       = tx_hold_q;
        state_d   = state_q;
        act_d     = act_q;
        clk_act_d = clk_act_q;
        pos_d     = pos_q;
        div_d     = div_q;
        pend_d    = pend_q;
        syncp_d   = syncp_q;
        pin_d     = pin_q;
        tx_hold_d = tx_hold_q;
        strobe_d  = 1'b0;
        fcnt_d    = fcnt_q;
        rx_sh_d   = rx_sh_q;
        rx_d      = rx_q;
        rx_d.valid = '0;
        launch    = 1'b0;
        start     = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // R21 options latched only when the port starts
                act_d     = cfg_q;
                clk_act_d = clk_reg_q;
                pos_d     = '1;
                pend_d    = 1'b0;
                div_d     = 8'h00;
                pin_d     = '0;
                if (cfg_q.run) begin
                    state_d = cfg_q.master ? ST_RUN : ST_HUNT;
                end
            end
            ST_HUNT, ST_RUN: begin
                if (!cfg_q.run) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // R1 master drives clock and sync
        if (state_q == ST_RUN && act_q.master) begin
            pin_d.clk_oe  = 1'b1;
            pin_d.sync_oe = 1'b1;
            if (div_q >= half_period(act_q, clk_act_q) - 8'h01) begin
                div_d       = 8'h00;
                pin_d.clk_o = !pin_q.clk_o;
            end else begin
                div_d = div_q + 8'h01;
            end
        end
        if (fall) begin
            syncp_d = sy2_q[1];
            if (!act_q.master) begin
                if (act_q.sync_fmt == SYNC_SHORT) begin
                    // R6 high sync at a fall: next rising edge starts
                    pend_d = sy2_q[1];
                end else if (sy2_q[1] && !syncp_q) begin
                    // R3 R5 R17 sync rise starts the word, any width
                    start = 1'b1;
                end
            end
        end
        // R22 slots counted from frame start without gaps
        if (rise) begin
            pend_d = 1'b0;
            launch = act_q.master || pend_q || state_q == ST_RUN;
            if (act_q.master) begin
                pos_d = (pos_q >= frame_last) ? '0 : pos_q + 11'h001;
            end else if (pend_q) begin
                pos_d = '0;
            end else if (!(&pos_q)) begin
                pos_d = pos_q + 11'h001;
            end
        end
        if (start) begin
            launch = 1'b1;
            pos_d  = '0;
        end
        if (launch && state_q == ST_HUNT && pos_d == '0 && cfg_q.run) begin
            state_d = ST_RUN;
        end
        if (launch && state_d == ST_RUN) begin
            if (pos_d == '0) begin
                // R13 R18 one sample per link per frame, straight from the link
                src       = link_tx;
                tx_hold_d = link_tx;
                strobe_d  = 1'b1;
                fcnt_d    = fcnt_q + 16'h0001;
            end
            // R7 R9 launch on rising edge, or on the fall that sees a slave sync start, in owned slots
            hit           = link_of(act_q, pos_d);
            b             = bit_in_slot(act_q, pos_d);
            w             = build_word(act_q, src.sample[hit[1:0]]);
            pin_d.data_oe = hit[2];
            if (hit[2]) begin
                pin_d.data_o = w[bit_index(act_q, b)];
            end
            if (act_q.master) begin
                // R4 R20 long width, R6 short one period, R16 GCI one period
                case (act_q.sync_fmt)
                    SYNC_LONG:  pin_d.sync_o = pos_d < ((act_q.hi_rate && act_q.long16) ?
                                               SYNC_LONG16_BITS : SYNC_LONG_BITS);
                    SYNC_SHORT: pin_d.sync_o = pos_d == frame_last;
                    default:    pin_d.sync_o = pos_d == '0;
                endcase
            end
        end
        if (fall && (state_q == ST_RUN || start) && cfg_q.run) begin
            hit = link_of(act_q, start ? '0 : pos_q);
            b   = bit_in_slot(act_q, start ? '0 : pos_q);
            // R8 early release during the last bit
            if (!act_q.late_release && pin_q.data_oe && b == slot_last(act_q) && !start) begin
                pin_d.data_oe = 1'b0;
            end
            if (hit[2]) begin
                // R7 capture on falling edge
                w = (b == 4'h0) ? 16'h0000 : rx_sh_q;
                w[bit_index(act_q, b)] = sy2_q[0];
                rx_sh_d = w;
                if (b == slot_last(act_q)) begin
                    rx_d.sample[hit[1:0]] = extract(act_q, w);
                    rx_d.valid[hit[1:0]]  = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= ST_IDLE;
            act_q     <= vps_cfg_type'(CONFIG_RESET);
            clk_act_q <= CLOCK_RESET;
            pos_q     <= '1;
            div_q     <= 8'h00;
            pend_q    <= 1'b0;
            syncp_q   <= 1'b0;
            pin_q     <= '0;
            tx_hold_q <= '0;
            strobe_q  <= 1'b0;
            fcnt_q    <= 16'h0000;
            rx_sh_q   <= 16'h0000;
            rx_q      <= '0;
        end else begin
            state_q   <= state_d;
            act_q     <= act_d;
            clk_act_q <= clk_act_d;
            pos_q     <= pos_d;
            div_q     <= div_d;
            pend_q    <= pend_d;
            syncp_q   <= syncp_d;
            pin_q     <= pin_d;
            tx_hold_q <= tx_hold_d;
            strobe_q  <= strobe_d;
            fcnt_q    <= fcnt_d;
            rx_sh_q   <= rx_sh_d;
            rx_q      <= rx_d;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign pin_out      = pin_q;
    assign link_rx      = rx_q;
    assign frame_strobe = strobe_q;

    // Checks; helper counts rising edges while master sync is high
    logic [POS_W-1:0] sync_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_cnt_q <= '0;
        end else begin
            sync_cnt_q <= !pin_q.sync_o ? '0 : sync_cnt_q + POS_W'(rise);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_strobe_pulse;
        frame_strobe ##1 !frame_strobe;
    endsequence

    AST_MASTER_DRIVES: assert property (state_q == ST_RUN && act_q.master // R1
        ##1 state_q == ST_RUN |-> pin_out.clk_oe && pin_out.sync_oe)
        else $error("master not driving clock");
    AST_SLAVE_HANDS_OFF: assert property (!act_q.master // R2
        |-> !pin_out.clk_oe && !pin_out.sync_oe) else $error("slave drives clock or sync");
    AST_LONG_SYNC_WIDTH: assert property (state_q == ST_RUN && act_q.master // R4
        && act_q.sync_fmt == SYNC_LONG && $fell(pin_out.sync_o)
        |-> sync_cnt_q == ((act_q.hi_rate && act_q.long16) ? SYNC_LONG16_BITS : SYNC_LONG_BITS))
        else $error("long sync width wrong");
    AST_SHORT_SYNC_ONE: assert property (state_q == ST_RUN && act_q.master // R6
        && act_q.sync_fmt == SYNC_SHORT && $fell(pin_out.sync_o) |-> sync_cnt_q == 11'h001)
        else $error("short sync not one period");
    // Idle clears the pins on purpose, so that step is not a launch
    AST_DATA_ON_LAUNCH: assert property ($changed(pin_out.data_o) // R7
        && $past(state_q) != ST_IDLE |-> $past(launch))
        else $error("output data changed off a launch edge");
    AST_RX_ON_FALL: assert property ($changed(rx_sh_q) |-> $past(fall)) // R7
        else $error("input captured off a falling edge");
    AST_EARLY_RELEASE: assert property (fall && state_q == ST_RUN && cfg_q.run && !start // R8
        && !act_q.late_release && pin_out.data_oe && fall_bit == slot_last(act_q)
        |=> !pin_out.data_oe) else $error("output not released in last bit");
    AST_OE_IN_OWNED_SLOT: assert property ($rose(pin_out.data_oe) // R9
        |-> link_of(act_q, pos_q) >= 3'h4) else $error("output driven outside an owned slot");
    AST_FRAME_STROBE: assert property (launch && state_d == ST_RUN && pos_d == '0 // R13
        |=> seq_strobe_pulse) else $error("frame strobe not a single pulse");
    AST_CFG_FROZEN: assert property (state_q != ST_IDLE && $past(state_q) != ST_IDLE // R21
        |-> $stable(act_q) && $stable(clk_act_q)) else $error("options changed while running");

endmodule // vps_voice_pcm_serial_port

// ---- test/test_vps_voice_pcm_serial_port.sv ----
// Purpose: Bench for the voice PCM serial port
// Assumes: APB answer taken at the rising edge that samples pready high
// Notes:   Master run uses data loopback, slave run uses the codec model
`timescale 1ns/10ps
module test_vps_voice_pcm_serial_port;
    import vps_pkg::*;
    logic            pclk, presetn, psel, penable, pwrite, slave, act;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic            pready, pslverr, er, frame_strobe;
    vps_pin_in_type  pin_in, mp;
    vps_pin_out_type pin_out;
    vps_link_tx_type link_tx;
    vps_link_rx_type link_rx;
    int              n_fail, cmp_count, n;
    vps_voice_pcm_serial_port uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .link_tx(link_tx), .link_rx(link_rx),
        .frame_strobe(frame_strobe));
    vps_codec_model codec (.act(act), .word(8'hA5), .pin(mp));
    // Pull-down on data input when our output is released
    assign pin_in = slave ? mp : {pin_out.clk_o, pin_out.sync_o,
                                  pin_out.data_oe & pin_out.data_o};
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bail();
        n_fail++;
        summarize();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Read before this edge's updates land: the values the slave showed
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) bail();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_rx();
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (link_rx.valid[0] !== 1'b1 && n < 8000);
        if (n >= 8000) bail();
    endtask
    task automatic wait_sync(input logic lvl);
        n = 0;
        while (pin_out.sync_o !== lvl && n < 8000) @(negedge pclk) n++;
        if (n >= 8000) bail();
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        slave   = 1'b0;
        act     = 1'b0;
        link_tx = {16'h0000, 16'h0000, 16'hC35A};
        n_fail    = 0;
        cmp_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        chk("config reset", CONFIG_RESET, rd);
        apb(1'b0, ADDR_CLOCK, 32'h0000_0000);
        chk("clock reset", CLOCK_RESET, rd);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, 32'(er));
        // Master, long sync, mu-law, link 0 in slot 0, high-rate source
        apb(1'b1, ADDR_CONFIG, 32'h0012_2021);
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        chk("config readback", 32'h0012_2021, rd);
        wait_sync(1'b1);
        chk("frame strobe", 32'h1, 32'(frame_strobe));
        wait_sync(1'b0);
        // Eight bit periods of 2 x 20 pclk
        chk("sync high cycles", 32'd320, 32'(n));
        chk("data released", 32'h0, 32'(pin_out.data_oe));
        chk("clock and sync driven", 32'h3,
            32'({pin_out.clk_oe, pin_out.sync_oe}));
        wait_rx();
        wait_rx();
        chk("master loopback", 32'h5A, 32'(link_rx.sample[0][7:0]));
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0003, rd & 32'h0000_FFFF);
        apb(1'b1, ADDR_CONFIG, 32'h0000_0000);
        // Master, short sync, 16-period slots, lin16, lsb first, late release
        apb(1'b1, ADDR_CONFIG, 32'h0012_30DB);
        wait_sync(1'b1);
        wait_sync(1'b0);
        chk("short sync cycles", 32'd40, 32'(n));
        wait_rx();
        wait_rx();
        chk("lin16 loopback", 32'hC35A, 32'(link_rx.sample[0]));
        apb(1'b1, ADDR_CONFIG, 32'h0000_0000);
        slave <= 1'b1;
        act   <= 1'b1;
        apb(1'b1, ADDR_CONFIG, 32'h0012_0020);
        wait_rx();
        wait_rx();
        chk("slave receive", 32'hA5, 32'(link_rx.sample[0][7:0]));
        chk("pins released", 32'h0,
            32'({pin_out.clk_oe, pin_out.sync_oe}));
        summarize();
    end
endmodule // test_vps_voice_pcm_serial_port

// ---- test/vps_codec_model.sv ----
// Purpose: Far-end codec that makes bit clock and long frame sync
// Assumes: 400 ns bit clock, 32-bit frames, one sync period
// Notes:   Clock stands still while act is low
`timescale 1ns/10ps
module vps_codec_model (
    input  wire logic                    act,
    input  wire logic [7:0]              word,
    output vps_pkg::vps_pin_in_type      pin
);
    import vps_pkg::*;
    always begin
        pin = '0;
        wait (act);
        for (int b = 0; b < 32; b++) begin
            // sync rises at word start, one period
            pin.sync = (b == 0);
            // launch on rise, MSB first; pull-down outside slot
            pin.data = (b < 8) ? word[7 - b] : 1'b0;
            pin.clk = 1'b1;
            #200;
            pin.clk = 1'b0;
            #200;
        end
    end
endmodule // vps_codec_model
